/* hdl/thermal_monitor_pkg.sv */
package thermal_monitor_pkg;

   // pointer codes of the readable registers
   localparam logic [7:0] PTR_LOCAL_TEMP = 8'h00;
   localparam logic [7:0] PTR_REMOTE2_TEMP = 8'h01;
   localparam logic [7:0] PTR_ALARM_FIRST = 8'h02;
   localparam logic [7:0] PTR_SETUP_READ = 8'h03;
   localparam logic [7:0] PTR_LOCAL_HIGH_READ = 8'h05;
   localparam logic [7:0] PTR_REMOTE2_HIGH_READ = 8'h07;
   localparam logic [7:0] PTR_REMOTE1_TEMP = 8'h30;
   localparam logic [7:0] PTR_REMOTE3_TEMP = 8'h31;
   localparam logic [7:0] PTR_ALARM_SECOND = 8'h35;
   localparam logic [7:0] PTR_REMOTE1_HIGH_READ = 8'h38;
   localparam logic [7:0] PTR_REMOTE3_HIGH_READ = 8'h3a;
   localparam logic [7:0] PTR_CRIT_READ = 8'h42;
   localparam logic [7:0] PTR_MAKER_ID = 8'hfe;
   localparam logic [7:0] PTR_DIE_REV = 8'hff;

   // pointer codes of the writable registers
   localparam logic [7:0] PTR_SETUP_WRITE = 8'h09;
   localparam logic [7:0] PTR_LOCAL_HIGH_WRITE = 8'h0b;
   localparam logic [7:0] PTR_REMOTE2_HIGH_WRITE = 8'h0d;
   localparam logic [7:0] PTR_REMOTE1_HIGH_WRITE = 8'h50;
   localparam logic [7:0] PTR_REMOTE3_HIGH_WRITE = 8'h52;
   localparam logic [7:0] PTR_CRIT_WRITE = 8'h5a;

   // reset values
   localparam logic [7:0] PTR_RESET = 8'h00;
   localparam logic [7:0] TEMP_RESET = 8'h00;
   localparam logic [7:0] LIMIT_RESET = 8'h7f;
   localparam logic [7:0] SETUP_RESET = 8'h00;

   // channel indices: 0 local, 1..3 remote diodes
   localparam int CH_LOCAL = 0;
   localparam int CH_REMOTE1 = 1;
   localparam int CH_REMOTE2 = 2;
   localparam int CH_REMOTE3 = 3;
   localparam int NUM_CH = 4;

   // setup register fields
   localparam int SETUP_INT_MASK = 7;
   localparam int SETUP_INT_INVERT = 1;
   localparam logic [7:0] SETUP_WRITABLE = 8'hbe;
   // critical mask bit position per channel: local, remote1, remote2, remote3
   localparam logic [2:0] CRIT_MASK_BIT [NUM_CH] = '{3'h2, 3'h5, 3'h4, 3'h3};

   // serial bit count of a byte
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // byte taken from the serial master
   typedef struct packed {
      logic valid;
      logic is_pointer;
      logic [7:0] data;
   } serial_write_t;

   // one converted sample set from the converter
   typedef struct packed {
      logic done;
      logic [NUM_CH-1:0] open;
      logic [NUM_CH-1:0][7:0] temp;
   } conversion_t;

endpackage : thermal_monitor_pkg

/* hdl/serial_slave.sv */
`timescale 1ns/1ps
module serial_slave (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // two-wire pins, already synchronised
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_oe_o,
   // own address
   input wire logic [6:0] addr_i,
   // register side
   output thermal_monitor_pkg::serial_write_t wr_o,
   output logic rd_pulse_o,
   input wire logic [7:0] rd_data_i
);

   typedef enum logic [2:0] {IDLE, ADDR, ACK, WRITE, READ, RACK} state_t;

   state_t state;
   logic scl_d;
   logic sda_d;
   logic [3:0] bit_cnt;
   logic [7:0] shreg;
   logic [7:0] tx;
   logic is_read;
   logic have_ptr;
   logic rise;
   logic fall;
   logic start;
   logic stop;

   // edge history on already synchronised levels
   always_ff @(posedge clk_i) begin
      scl_d <= scl_i;
      sda_d <= sda_i;
   end

   // bus events; a start always restarts the frame at the address byte
   assign rise = scl_i & ~scl_d;
   assign fall = ~scl_i & scl_d;
   assign start = scl_i & scl_d & sda_d & ~sda_i;
   assign stop = scl_i & scl_d & ~sda_d & sda_i;

   // frame sequencer
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         state <= IDLE;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         tx <= 8'h00;
         is_read <= 1'b0;
         have_ptr <= 1'b0;
         sda_oe_o <= 1'b0;
         wr_o <= '0;
         rd_pulse_o <= 1'b0;
      end else begin
         wr_o.valid <= 1'b0;
         rd_pulse_o <= 1'b0;
         if (start) begin
            state <= ADDR;
            bit_cnt <= 4'h0;
            have_ptr <= 1'b0;
            sda_oe_o <= 1'b0;
         end else if (stop) begin
            state <= IDLE;
            sda_oe_o <= 1'b0;
         end else begin
            case (state)
               ADDR, WRITE: begin
                  if (rise && bit_cnt != thermal_monitor_pkg::BITS_PER_BYTE) begin
                     shreg <= {shreg[6:0], sda_i};
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (fall && bit_cnt == thermal_monitor_pkg::BITS_PER_BYTE) begin
                     bit_cnt <= 4'h0;
                     if (state == ADDR) begin
                        if (shreg[7:1] == addr_i) begin
                           is_read <= shreg[0];
                           sda_oe_o <= 1'b1;
                           state <= ACK;
                        end else begin
                           state <= IDLE;
                        end
                     end else begin
                        // first byte of a write is the pointer, the rest is data
                        wr_o.valid <= 1'b1;
                        wr_o.is_pointer <= ~have_ptr;
                        wr_o.data <= shreg;
                        have_ptr <= 1'b1;
                        sda_oe_o <= 1'b1;
                        state <= ACK;
                     end
                  end
               end
               ACK: begin
                  if (fall) begin
                     if (is_read) begin
                        // same register again on every byte: the pointer does not advance
                        tx <= rd_data_i;
                        rd_pulse_o <= 1'b1;
                        sda_oe_o <= ~rd_data_i[7];
                        bit_cnt <= 4'h1;
                        state <= READ;
                     end else begin
                        sda_oe_o <= 1'b0;
                        state <= WRITE;
                     end
                  end
               end
               READ: begin
                  if (fall) begin
                     if (bit_cnt == thermal_monitor_pkg::BITS_PER_BYTE) begin
                        sda_oe_o <= 1'b0;
                        state <= RACK;
                     end else begin
                        sda_oe_o <= ~tx[3'h7 - bit_cnt[2:0]];
                        bit_cnt <= bit_cnt + 4'h1;
                     end
                  end
               end
               RACK: begin
                  // master ack asks for another byte, nack ends the read
                  if (rise) begin
                     state <= sda_i ? IDLE : ACK;
                  end
               end
               default: begin
                  state <= IDLE;
                  sda_oe_o <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule : serial_slave

/* hdl/thermal_monitor_regs.sv */
`timescale 1ns/1ps
//
// Contract
// - pointer selects register for serial accesses
// - temperatures at 00h,01h,30h,31h, reset zero
// - temperatures eight-bit two's complement, MSB first
// - first status at 02h, resets zero
// - first status bit0: local critical alarm
// - first status bit1: remote2 critical alarm
// - first status bit2: remote2 disconnected
// - first status bit4: remote2 over high
// - first status bit6: local over high
// - first status bits 7,5,3 read zero
// - second status at 35h, resets zero
// - high limits read 05h,07h,38h,3Ah, reset 127
// - high limits written 0Bh,0Dh,50h,52h
// - critical limit read 42h, write 5Ah
// - maker id FEh, die revision FFh
// - setup read 03h, written 09h
// - read and write twins share storage
// - pointer resets zero, holds last value
// - status read clears open flags, and limit flags unless fault persists
//
module thermal_monitor_regs #(
   parameter logic [7:0] MAKER_ID = 8'h3c, // arbitrary value
   parameter logic [7:0] DIE_REV = 8'h07 // arbitrary value
) (
   // clock and reset
   input wire logic CORE_CLK_I,
   input wire logic RST_B_I,
   // two-wire management bus
   input wire logic SMB_CLK_I,
   input wire logic SMB_DATA_I,
   output logic SMB_DATA_O,
   output logic SMB_DATA_OE_O,
   input wire logic [6:0] SLAVE_ADDR_I,
   // converter results, same clock domain
   input wire thermal_monitor_pkg::conversion_t CONV_I,
   // open-drain alarm pins, high while pulling low
   output logic INT_PULL_LOW_O,
   output logic CRIT_PULL_LOW_O
);

   localparam int NCH = thermal_monitor_pkg::NUM_CH;

   // pin synchronisers
   logic scl_meta;
   logic scl_sync;
   logic sda_meta;
   logic sda_sync;
   logic [6:0] addr_meta;
   logic [6:0] addr_sync;

   // register storage
   logic [7:0] register_pointer;
   logic [7:0] temp_value [NCH];
   logic [7:0] high_limit [NCH];
   logic [7:0] critical_limit_value;
   logic [7:0] setup;

   // sticky flags per channel
   logic [NCH-1:0] crit_flag;
   logic [NCH-1:0] high_flag;
   logic [NCH-1:0] open_flag;
   logic [NCH-1:0] crit_now;
   logic [NCH-1:0] high_now;
   logic [NCH-1:0] crit_cause;
   logic [NCH-1:0] high_cause;
   logic [NCH-1:0] clear_sel;

   // serial engine hookup
   thermal_monitor_pkg::serial_write_t wr;
   logic rd_pulse;
   logic [7:0] rd_data;
   logic data_wr;
   logic read_first;
   logic read_second;
   logic [7:0] alarm_flags_first;
   logic [7:0] alarm_flags_second;

   // two flops on every pin; only the second flop is read by logic
   always_ff @(posedge CORE_CLK_I) begin
      scl_meta <= SMB_CLK_I;
      scl_sync <= scl_meta;
      sda_meta <= SMB_DATA_I;
      sda_sync <= sda_meta;
      addr_meta <= SLAVE_ADDR_I;
      addr_sync <= addr_meta;
   end

   // byte engine: address match, ack, shifting MSB first
   serial_slave u_serial (
      .clk_i(CORE_CLK_I),
      .rst_b_i(RST_B_I),
      .scl_i(scl_sync),
      .sda_i(sda_sync),
      .sda_oe_o(SMB_DATA_OE_O),
      .addr_i(addr_sync),
      .wr_o(wr),
      .rd_pulse_o(rd_pulse),
      .rd_data_i(rd_data)
   );

   // open drain: the data level driven is always low
   assign SMB_DATA_O = 1'b0;

   assign data_wr = wr.valid & ~wr.is_pointer;

   // pointer taken from the command byte only
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_B_I) begin
         register_pointer <= thermal_monitor_pkg::PTR_RESET;
      end else if (wr.valid && wr.is_pointer) begin
         register_pointer <= wr.data;
      end
   end

   // temperature samples are taken as delivered by the converter
   generate
      for (genvar ch = 0; ch < NCH; ch++) begin : g_temp
         always_ff @(posedge CORE_CLK_I) begin
            if (!RST_B_I) begin
               temp_value[ch] <= thermal_monitor_pkg::TEMP_RESET;
            end else if (CONV_I.done) begin
               temp_value[ch] <= CONV_I.temp[ch];
            end
         end
      end
   endgenerate

   // high limits: one store serves both read and write codes
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_B_I) begin
         for (int ch = 0; ch < NCH; ch++) begin
            high_limit[ch] <= thermal_monitor_pkg::LIMIT_RESET;
         end
      end else if (data_wr) begin
         case (register_pointer)
            thermal_monitor_pkg::PTR_LOCAL_HIGH_WRITE: begin
               high_limit[thermal_monitor_pkg::CH_LOCAL] <= wr.data;
            end
            thermal_monitor_pkg::PTR_REMOTE1_HIGH_WRITE: begin
               high_limit[thermal_monitor_pkg::CH_REMOTE1] <= wr.data;
            end
            thermal_monitor_pkg::PTR_REMOTE2_HIGH_WRITE: begin
               high_limit[thermal_monitor_pkg::CH_REMOTE2] <= wr.data;
            end
            thermal_monitor_pkg::PTR_REMOTE3_HIGH_WRITE: begin
               high_limit[thermal_monitor_pkg::CH_REMOTE3] <= wr.data;
            end
            default: begin
               // read-only and reserved codes leave storage alone
            end
         endcase
      end
   end

   // critical limit
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_B_I) begin
         critical_limit_value <= thermal_monitor_pkg::LIMIT_RESET;
      end else if (data_wr && register_pointer == thermal_monitor_pkg::PTR_CRIT_WRITE) begin
         critical_limit_value <= wr.data;
      end
   end

   // setup register; reserved bits 6 and 0 are never stored
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_B_I) begin
         setup <= thermal_monitor_pkg::SETUP_RESET;
      end else if (data_wr && register_pointer == thermal_monitor_pkg::PTR_SETUP_WRITE) begin
         setup <= wr.data & thermal_monitor_pkg::SETUP_WRITABLE;
      end
   end

   // live comparisons of stored samples against limits, signed
   generate
      for (genvar ch = 0; ch < NCH; ch++) begin : g_cmp
         assign crit_now[ch] = $signed(temp_value[ch]) > $signed(critical_limit_value);
         assign high_now[ch] = $signed(temp_value[ch]) > $signed(high_limit[ch]);
         // at completion the fresh sample is what counts
         assign crit_cause[ch] = $signed(CONV_I.temp[ch]) > $signed(critical_limit_value);
         assign high_cause[ch] = $signed(CONV_I.temp[ch]) > $signed(high_limit[ch]);
      end
   endgenerate

   // which status register a read just touched
   assign read_first = rd_pulse && register_pointer == thermal_monitor_pkg::PTR_ALARM_FIRST;
   assign read_second = rd_pulse && register_pointer == thermal_monitor_pkg::PTR_ALARM_SECOND;

   // channels shown in each status register
   assign clear_sel[thermal_monitor_pkg::CH_LOCAL] = read_first;
   assign clear_sel[thermal_monitor_pkg::CH_REMOTE2] = read_first;
   assign clear_sel[thermal_monitor_pkg::CH_REMOTE1] = read_second;
   assign clear_sel[thermal_monitor_pkg::CH_REMOTE3] = read_second;

   // sticky flags: set at conversion end, a read clears open flags and any limit flag that no longer faults;
   // a set landing in the read cycle wins so no event is lost
   generate
      for (genvar ch = 0; ch < NCH; ch++) begin : g_flag
         always_ff @(posedge CORE_CLK_I) begin
            if (!RST_B_I) begin
               crit_flag[ch] <= 1'b0;
               high_flag[ch] <= 1'b0;
               open_flag[ch] <= 1'b0;
            end else begin
               crit_flag[ch] <= (CONV_I.done & crit_cause[ch])
                  | (clear_sel[ch] ? crit_now[ch] : crit_flag[ch]);
               high_flag[ch] <= (CONV_I.done & high_cause[ch])
                  | (clear_sel[ch] ? high_now[ch] : high_flag[ch]);
               // the local channel has no diode to lose
               open_flag[ch] <= (ch != thermal_monitor_pkg::CH_LOCAL)
                  & ((CONV_I.done & CONV_I.open[ch]) | (~clear_sel[ch] & open_flag[ch]));
            end
         end
      end
   endgenerate

   // status packing; reserved positions are constant zero
   assign alarm_flags_first = {
      1'b0,
      high_flag[thermal_monitor_pkg::CH_LOCAL],
      1'b0,
      high_flag[thermal_monitor_pkg::CH_REMOTE2],
      1'b0,
      open_flag[thermal_monitor_pkg::CH_REMOTE2],
      crit_flag[thermal_monitor_pkg::CH_REMOTE2],
      crit_flag[thermal_monitor_pkg::CH_LOCAL]
   };
   assign alarm_flags_second = {
      high_flag[thermal_monitor_pkg::CH_REMOTE1],
      1'b0,
      open_flag[thermal_monitor_pkg::CH_REMOTE1],
      high_flag[thermal_monitor_pkg::CH_REMOTE3],
      1'b0,
      open_flag[thermal_monitor_pkg::CH_REMOTE3],
      crit_flag[thermal_monitor_pkg::CH_REMOTE3],
      crit_flag[thermal_monitor_pkg::CH_REMOTE1]
   };

   // read mux steered by the pointer; write-only and reserved codes read zero
   always_comb begin
      case (register_pointer)
         thermal_monitor_pkg::PTR_LOCAL_TEMP: rd_data = temp_value[thermal_monitor_pkg::CH_LOCAL];
         thermal_monitor_pkg::PTR_REMOTE2_TEMP: rd_data = temp_value[thermal_monitor_pkg::CH_REMOTE2];
         thermal_monitor_pkg::PTR_REMOTE1_TEMP: rd_data = temp_value[thermal_monitor_pkg::CH_REMOTE1];
         thermal_monitor_pkg::PTR_REMOTE3_TEMP: rd_data = temp_value[thermal_monitor_pkg::CH_REMOTE3];
         thermal_monitor_pkg::PTR_ALARM_FIRST: rd_data = alarm_flags_first;
         thermal_monitor_pkg::PTR_ALARM_SECOND: rd_data = alarm_flags_second;
         thermal_monitor_pkg::PTR_SETUP_READ: rd_data = setup;
         thermal_monitor_pkg::PTR_LOCAL_HIGH_READ: rd_data = high_limit[thermal_monitor_pkg::CH_LOCAL];
         thermal_monitor_pkg::PTR_REMOTE2_HIGH_READ: rd_data = high_limit[thermal_monitor_pkg::CH_REMOTE2];
         thermal_monitor_pkg::PTR_REMOTE1_HIGH_READ: rd_data = high_limit[thermal_monitor_pkg::CH_REMOTE1];
         thermal_monitor_pkg::PTR_REMOTE3_HIGH_READ: rd_data = high_limit[thermal_monitor_pkg::CH_REMOTE3];
         thermal_monitor_pkg::PTR_CRIT_READ: rd_data = critical_limit_value;
         thermal_monitor_pkg::PTR_MAKER_ID: rd_data = MAKER_ID;
         thermal_monitor_pkg::PTR_DIE_REV: rd_data = DIE_REV;
         default: rd_data = 8'h00;
      endcase
   end

   // alarm pins; a masked flag still shows in status but not on the pin
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_B_I) begin
         CRIT_PULL_LOW_O <= 1'b0;
         INT_PULL_LOW_O <= 1'b0;
      end else begin
         CRIT_PULL_LOW_O <= 1'b0;
         for (int ch = 0; ch < NCH; ch++) begin
            if (crit_flag[ch] && !setup[thermal_monitor_pkg::CRIT_MASK_BIT[ch]]) begin
               CRIT_PULL_LOW_O <= 1'b1;
            end
         end
         // inversion makes the idle state the pulled one
         INT_PULL_LOW_O <= ((|high_flag) & ~setup[thermal_monitor_pkg::SETUP_INT_MASK])
            ^ setup[thermal_monitor_pkg::SETUP_INT_INVERT];
      end
   end

endmodule : thermal_monitor_regs

/* dv/smbus_host_model.sv */
`timescale 1ns/1ps
module smbus_host_model (
   // core clock paces the bus
   input wire logic clk_i,
   // bus pins, pull high means pulling data low
   output logic scl_o,
   output logic sda_pull_o,
   input wire logic sda_i
);
   // bus clock stands high between frames
   initial begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
   end

   // a quarter of the 400 ns bus period
   task automatic q;
      repeat (2) @(posedge clk_i);
   endtask : q

   // data moves a quarter period into the low phase, a cycle before the device lets go of its ack
   task automatic bit_io(input logic v, output logic s);
      q;
      sda_pull_o <= ~v;
      q;
      q;
      scl_o <= 1'b1;
      q;
      s = sda_i;
      scl_o <= 1'b0;
   endtask : bit_io

   // start or repeated start, data falls while clock high
   task automatic start_cond;
      q;
      q;
      sda_pull_o <= 1'b0;
      q;
      scl_o <= 1'b1;
      q;
      sda_pull_o <= 1'b1;
      q;
      scl_o <= 1'b0;
   endtask : start_cond

   // stop, data rises while clock high
   task automatic stop_cond;
      q;
      sda_pull_o <= 1'b1;
      q;
      scl_o <= 1'b1;
      q;
      sda_pull_o <= 1'b0;
      q;
   endtask : stop_cond

   // eight bits msb first, then the ninth bit
   task automatic byte_io(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(last, b);
      ack = ~b;
   endtask : byte_io

   task automatic reg_write(input logic [6:0] a, input logic [7:0] ptr, input logic [7:0] d);
      logic [7:0] rx;
      logic ack;
      start_cond;
      byte_io({a, 1'b0}, 1'b1, rx, ack);
      byte_io(ptr, 1'b1, rx, ack);
      byte_io(d, 1'b1, rx, ack);
      stop_cond;
   endtask : reg_write

   // single byte read, ended by a nack
   task automatic reg_read(input logic [6:0] a, input logic [7:0] ptr, input logic set, output logic [7:0] d,
                           output logic ack);
      logic [7:0] rx;
      logic nack;
      start_cond;
      if (set) begin
         byte_io({a, 1'b0}, 1'b1, rx, ack);
         byte_io(ptr, 1'b1, rx, ack);
         start_cond;
      end
      byte_io({a, 1'b1}, 1'b1, rx, ack);
      byte_io(8'hff, 1'b1, d, nack);
      stop_cond;
   endtask : reg_read
endmodule : smbus_host_model

/* dv/thermal_monitor_regs_properties.sv */
`timescale 1ns/1ps
module thermal_monitor_regs_properties (
   // clock and reset
   input wire logic CORE_CLK_I,
   input wire logic RST_B_I,
   // two-wire bus
   input wire logic SMB_CLK_I,
   input wire logic SMB_DATA_I,
   input wire logic SMB_DATA_O,
   input wire logic SMB_DATA_OE_O,
   input wire logic [6:0] SLAVE_ADDR_I,
   // converter and alarms
   input wire thermal_monitor_pkg::conversion_t CONV_I,
   input wire logic INT_PULL_LOW_O,
   input wire logic CRIT_PULL_LOW_O
);
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RST_B_I);

   logic [4:0] since_oe;
   logic [4:0] clk_high_run;

   // cycles since the device last pulled data, saturating
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_B_I || SMB_DATA_OE_O) begin
         since_oe <= 5'h00;
      end else if (since_oe != 5'h1f) begin
         since_oe <= since_oe + 5'h01;
      end
   end

   // length of the current high stretch of the bus clock
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_B_I || !SMB_CLK_I) begin
         clk_high_run <= 5'h00;
      end else if (clk_high_run != 5'h1f) begin
         clk_high_run <= clk_high_run + 5'h01;
      end
   end

   property p_reset_quiet;
      $rose(RST_B_I) |-> !SMB_DATA_OE_O && !INT_PULL_LOW_O && !CRIT_PULL_LOW_O;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
   property p_data_level;
      SMB_DATA_O == 1'b0;
   endproperty
   a_data_level: assert property (p_data_level) else $error("data level not low");
   // a data change while clock high would look like start or stop
   property p_oe_clk_low;
      $changed(SMB_DATA_OE_O) |-> !SMB_CLK_I;
   endproperty
   a_oe_clk_low: assert property (p_oe_clk_low) else $error("data moved with clock high");
   property p_oe_stands;
      $rose(SMB_DATA_OE_O) |-> SMB_DATA_OE_O [*4];
   endproperty
   a_oe_stands: assert property (p_oe_stands) else $error("data pull too short");
   property p_idle_quiet;
      clk_high_run > 5'h0c |-> !SMB_DATA_OE_O;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("data pulled on idle bus");
   property p_int_rise;
      $rose(INT_PULL_LOW_O) |-> $past(CONV_I.done, 2);
   endproperty
   a_int_rise: assert property (p_int_rise) else $error("alarm without conversion");
   property p_crit_rise;
      $rose(CRIT_PULL_LOW_O) |-> $past(CONV_I.done, 2);
   endproperty
   a_crit_rise: assert property (p_crit_rise) else $error("critical without conversion");
   property p_alarm_release;
      ($fell(INT_PULL_LOW_O) || $fell(CRIT_PULL_LOW_O)) |-> since_oe < 5'h10;
   endproperty
   a_alarm_release: assert property (p_alarm_release) else $error("alarm fell without read");

   c_int_rise: cover property ($rose(INT_PULL_LOW_O));
   c_ack: cover property ($rose(SMB_DATA_OE_O));
   c_release: cover property ($fell(CRIT_PULL_LOW_O));
endmodule : thermal_monitor_regs_properties

bind thermal_monitor_regs thermal_monitor_regs_properties u_props (
   .CORE_CLK_I(CORE_CLK_I), .RST_B_I(RST_B_I), .SMB_CLK_I(SMB_CLK_I), .SMB_DATA_I(SMB_DATA_I),
   .SMB_DATA_O(SMB_DATA_O), .SMB_DATA_OE_O(SMB_DATA_OE_O), .SLAVE_ADDR_I(SLAVE_ADDR_I), .CONV_I(CONV_I),
   .INT_PULL_LOW_O(INT_PULL_LOW_O), .CRIT_PULL_LOW_O(CRIT_PULL_LOW_O)
);

/* dv/thermal_monitor_regs_test.sv */
`timescale 1ns/1ps
module thermal_monitor_regs_test;
   localparam logic [7:0] MAKER = 8'h5a; // arbitrary value
   localparam logic [7:0] REV = 8'h12; // arbitrary value
   localparam logic [6:0] ADDR = 7'h2a;

   logic core_clk;
   logic rst_b;
   logic scl;
   logic host_pull;
   logic dut_oe;
   logic int_pl;
   logic crit_pl;
   wire logic sda_line;
   thermal_monitor_pkg::conversion_t conv;
   int n_errors;
   int n_tests;

   // open-drain data line with pull-up
   assign sda_line = ~(host_pull | dut_oe);

   smbus_host_model host (.clk_i(core_clk), .scl_o(scl), .sda_pull_o(host_pull), .sda_i(sda_line));

   thermal_monitor_regs #(.MAKER_ID(MAKER), .DIE_REV(REV)) dut (
      .CORE_CLK_I(core_clk), .RST_B_I(rst_b), .SMB_CLK_I(scl), .SMB_DATA_I(sda_line), .SMB_DATA_O(),
      .SMB_DATA_OE_O(dut_oe), .SLAVE_ADDR_I(ADDR), .CONV_I(conv), .INT_PULL_LOW_O(int_pl),
      .CRIT_PULL_LOW_O(crit_pl)
   );

   // 20 MHz core clock
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   task automatic wrap_up;
      if (n_errors == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : wrap_up

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : check

   task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
      logic [7:0] d;
      logic a;
      host.reg_read(ADDR, ptr, 1'b1, d, a);
      check(d, exp);
   endtask : rd

   // one-cycle result pulse, then room for the alarm pins to settle
   task automatic convert(input logic [3:0] op, input logic [31:0] t);
      @(posedge core_clk);
      conv <= '{done: 1'b1, open: op, temp: t};
      @(posedge core_clk);
      conv.done <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask : convert

   // power-up values; the host never touches reserved codes
   task automatic t_reset;
      logic [7:0] d;
      logic a;
      logic [15:0] tbl [15] = '{16'h0000, 16'h0100, 16'h0200, 16'h0300, 16'h057f, 16'h077f, 16'h3000,
                                16'h3100, 16'h3500, 16'h387f, 16'h3a7f, 16'h427f, 16'h0000,
                                {8'hfe, MAKER}, {8'hff, REV}};
      host.reg_read(ADDR, 8'h00, 1'b0, d, a);
      check(d, 8'h00);
      foreach (tbl[i]) begin
         rd(tbl[i][15:8], tbl[i][7:0]);
      end
      host.reg_read(ADDR ^ 7'h01, 8'h00, 1'b0, d, a);
      check({7'h00, a}, 8'h00);
   endtask : t_reset

   // each write code shows in its read twin; setup bits 6 and 0 drop
   task automatic t_writes;
      logic [7:0] d;
      logic a;
      logic [23:0] tbl [6] = '{24'h0b0519, 24'h0d0719, 24'h503864, 24'h523a7d, 24'h5a4232, 24'h09037d};
      foreach (tbl[i]) begin
         host.reg_write(ADDR, tbl[i][23:16], tbl[i][7:0]);
         rd(tbl[i][15:8], tbl[i][7:0] & ((i == 5) ? 8'hbe : 8'hff));
      end
      // writes aimed at read-only codes change nothing, then setup is cleared; reserved codes stay untouched
      host.reg_write(ADDR, 8'h05, 8'h00);
      host.reg_write(ADDR, 8'h42, 8'h00);
      rd(8'h42, 8'h32);
      rd(8'h05, 8'h19);
      host.reg_read(ADDR, 8'h00, 1'b0, d, a);
      check(d, 8'h19);
      host.reg_write(ADDR, 8'h09, 8'h00);
      rd(8'h03, 8'h00);
   endtask : t_writes

   // hot sample raises flags and pins; reads clear open flags and only the limit flags that have cooled;
   // masked channels still flag in status but leave the pins alone
   task automatic t_conv;
      convert(4'b0100, {8'h00, 8'h33, 8'hc9, 8'h40});
      check({6'h00, crit_pl, int_pl}, 8'h03);
      rd(8'h00, 8'h40);
      rd(8'h01, 8'h33);
      rd(8'h30, 8'hc9);
      rd(8'h31, 8'h00);
      rd(8'h02, 8'h57);
      rd(8'h02, 8'h53);
      convert(4'h0, 32'h0);
      rd(8'h02, 8'h53);
      check({6'h00, crit_pl, int_pl}, 8'h00);
      rd(8'h02, 8'h00);
      host.reg_write(ADDR, 8'h09, 8'h94);
      convert(4'b0100, {8'h00, 8'h33, 8'hc9, 8'h40});
      check({6'h00, crit_pl, int_pl}, 8'h00);
      rd(8'h02, 8'h57);
   endtask : t_conv

   // main sequence
   initial begin
      n_errors = 0;
      n_tests = 0;
      rst_b = 1'b0;
      conv = '0;
      repeat (20) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge core_clk);
      t_reset;
      t_writes;
      t_conv;
      wrap_up;
   end

   // whole run needs about two thirds of a millisecond
   initial begin
      #2_000_000;
      n_errors++;
      wrap_up;
   end
endmodule : thermal_monitor_regs_test
